/* File: hw/fcs_top.v */
`include "fcs_regs.vh"

module fcs_top #(
  parameter AW = 20
) (
  input wire core_clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire [AW-1:0] fl_addr,
  output wire [15:0] fl_dq_out,
  input wire [15:0] fl_dq_in,
  output wire fl_dq_oe_n,
  output wire fl_ce_n,
  output wire fl_we_n,
  output wire fl_oe_n,
  output wire fl_byte_n,
  input wire ready_busy_n
);
  localparam [8:0] S_IDLE = 9'b000000001;
  localparam [8:0] S_SEQ = 9'b000000010;
  localparam [8:0] S_SEQW = 9'b000000100;
  localparam [8:0] S_POLL = 9'b000001000;
  localparam [8:0] S_POLLW = 9'b000010000;
  localparam [8:0] S_FIN = 9'b000100000;
  localparam [8:0] S_FINW = 9'b001000000;
  localparam [8:0] S_FAIL = 9'b010000000;
  localparam [8:0] S_FAILW = 9'b100000000;
  localparam SW = AW + 18;

  reg [31:0] wb_dat_reg;
  reg wb_ack_reg;
  reg [3:0] cmd_reg;
  reg [31:0] addr_reg;
  reg [15:0] data_reg;
  reg byte_n_reg;
  reg [8:0] state_reg;
  reg [2:0] step_reg;
  reg bypass_reg;
  reg erasing_reg;
  reg sector_erase_reg;
  reg suspended_reg;
  reg id_mode_reg;
  reg error_reg;
  reg refused_reg;
  reg protected_reg;
  reg poll_exp_reg;
  reg recheck_reg;
  reg [AW-1:0] poll_addr_reg;
  reg [AW-1:0] erase_addr_reg;
  reg [15:0] rdata_reg;
  reg cyc_go_reg;
  reg cyc_wr_reg;
  reg [AW-1:0] cyc_addr_reg;
  reg [15:0] cyc_wdata_reg;

  wire [16:0] sync_vec;
  wire [15:0] dq_sync;
  wire ready_sync;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire wb_req;
  wire [31:0] wb_mask;
  wire start_req;
  wire [AW-1:0] a_in;
  wire [SW-1:0] step_w;
  wire step_last;
  reg cmd_ok;
  reg [31:0] status_w;

  assign wb_dat_o = wb_dat_reg;
  assign wb_ack_o = wb_ack_reg;
  assign fl_byte_n = byte_n_reg;
  assign dq_sync = sync_vec[15:0];
  assign ready_sync = sync_vec[16];
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  assign wb_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign start_req = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FCS_OFF_CMD);
  assign a_in = addr_reg[AW-1:0];

  fcs_sync #(.W(17)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({ready_busy_n, fl_dq_in}),
    .sync_out(sync_vec)
  );

  fcs_cycle #(.AW(AW)) u_cycle (
    .core_clk(core_clk),
    .srst(srst),
    .go(cyc_go_reg),
    .wr(cyc_wr_reg),
    .addr(cyc_addr_reg),
    .wdata(cyc_wdata_reg),
    .dq_sync(dq_sync),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  // Packed step: {last, write, address, data}
  function [SW-1:0] wr8;
    input l;
    input [AW-1:0] ad;
    input [7:0] dt;
    begin
      wr8 = {l, 1'b1, ad, 8'h00, dt};
    end
  endfunction

  function [AW-1:0] ext12;
    input [11:0] v;
    begin
      ext12 = {{(AW-12){1'b0}}, v};
    end
  endfunction

  function [SW-1:0] step_f;
    input [3:0] c;
    input [2:0] s;
    input bm;
    input [AW-1:0] a;
    input [15:0] d;
    reg [AW-1:0] ua;
    reg [AW-1:0] ub;
    reg [AW-1:0] z;
    begin
      ua = bm ? ext12(`FCS_A_BYTE1) : ext12(`FCS_A_WORD1);
      ub = bm ? ext12(`FCS_A_BYTE2) : ext12(`FCS_A_WORD2);
      z = {AW{1'b0}};
      step_f = wr8(1'b1, z, `FCS_D_RESET);
      case (c)
        `FCS_CMD_READ: step_f = {1'b1, 1'b0, a, 16'h0000};
        `FCS_CMD_PROG, `FCS_CMD_BYP_ENTER, `FCS_CMD_PROTECT: begin
          case (s)
            3'd0: step_f = wr8(1'b0, ua, `FCS_D_UNLOCK1);
            3'd1: step_f = wr8(1'b0, ub, `FCS_D_UNLOCK2);
            3'd2: begin
              if (c == `FCS_CMD_PROG) begin
                step_f = wr8(1'b0, ua, `FCS_D_PROG);
              end else if (c == `FCS_CMD_BYP_ENTER) begin
                step_f = wr8(1'b1, ua, `FCS_D_BYPASS);
              end else begin
                step_f = wr8(1'b0, ua, `FCS_D_AUTOSEL);
              end
            end
            3'd3: begin
              if (c == `FCS_CMD_PROG) begin
                step_f = {1'b1, 1'b1, a, d};
              end else begin
                step_f = {1'b0, 1'b0, a | (bm ? ext12(`FCS_A_PV_BYTE) : ext12(`FCS_A_PV_WORD)),
                          16'h0000};
              end
            end
            default: step_f = wr8(1'b1, z, `FCS_D_RESET);
          endcase
        end
        `FCS_CMD_BYP_PROG: begin
          step_f = (s == 3'd0) ? wr8(1'b0, z, `FCS_D_PROG) : {1'b1, 1'b1, a, d};
        end
        `FCS_CMD_BYP_EXIT: begin
          step_f = (s == 3'd0) ? wr8(1'b0, z, `FCS_D_BYP_EXIT1) :
                   wr8(1'b1, z, `FCS_D_BYP_EXIT2);
        end
        `FCS_CMD_CHIP_ERASE, `FCS_CMD_SECT_ERASE: begin
          case (s)
            3'd0: step_f = wr8(1'b0, ua, `FCS_D_UNLOCK1);
            3'd1: step_f = wr8(1'b0, ub, `FCS_D_UNLOCK2);
            3'd2: step_f = wr8(1'b0, ua, `FCS_D_ERASE);
            3'd3: step_f = wr8(1'b0, ua, `FCS_D_UNLOCK1);
            3'd4: step_f = wr8(1'b0, ub, `FCS_D_UNLOCK2);
            default: begin
              step_f = (c == `FCS_CMD_CHIP_ERASE) ? wr8(1'b1, ua, `FCS_D_CHIP) :
                       wr8(1'b1, a, `FCS_D_SECTOR);
            end
          endcase
        end
        `FCS_CMD_SUSPEND: step_f = wr8(1'b1, z, `FCS_D_SUSPEND);
        `FCS_CMD_RESUME: step_f = wr8(1'b1, z, `FCS_D_RESUME);
        `FCS_CMD_CFI: begin
          step_f = wr8(1'b1, bm ? ext12(`FCS_A_CFI_BYTE) : ext12(`FCS_A_CFI_WORD), `FCS_D_CFI);
        end
        default: step_f = wr8(1'b1, z, `FCS_D_RESET);
      endcase
    end
  endfunction

  assign step_w = step_f(cmd_reg, step_reg, ~byte_n_reg, a_in, data_reg);
  assign step_last = step_w[SW-1];

  // Commands that the flash would ignore are refused here
  always @* begin
    cmd_ok = 1'b0;
    case (wb_dat_i[3:0])
      `FCS_CMD_READ: cmd_ok = ~erasing_reg | suspended_reg;
      `FCS_CMD_PROG: cmd_ok = ~bypass_reg & ~id_mode_reg & (~erasing_reg | suspended_reg);
      `FCS_CMD_BYP_ENTER: cmd_ok = ~bypass_reg & ~id_mode_reg & ~erasing_reg;
      `FCS_CMD_BYP_PROG: cmd_ok = bypass_reg & ~erasing_reg;
      `FCS_CMD_BYP_EXIT: cmd_ok = bypass_reg;
      `FCS_CMD_CHIP_ERASE: cmd_ok = ~bypass_reg & ~id_mode_reg & ~erasing_reg;
      `FCS_CMD_SECT_ERASE: cmd_ok = ~bypass_reg & ~id_mode_reg & ~erasing_reg;
      `FCS_CMD_SUSPEND: cmd_ok = erasing_reg & sector_erase_reg & ~suspended_reg;
      `FCS_CMD_RESUME: cmd_ok = suspended_reg & ~id_mode_reg;
      `FCS_CMD_CFI: cmd_ok = ~bypass_reg & ~erasing_reg;
      `FCS_CMD_RESET: cmd_ok = ~bypass_reg;
      `FCS_CMD_PROTECT: cmd_ok = ~bypass_reg & ~id_mode_reg & (~erasing_reg | suspended_reg);
      `FCS_CMD_POLL: cmd_ok = erasing_reg & ~suspended_reg;
      default: cmd_ok = 1'b0;
    endcase
  end

  always @* begin
    status_w = 32'h0000_0000;
    status_w[`FCS_ST_BUSY] = ~state_reg[0];
    status_w[`FCS_ST_READY] = ready_sync;
    status_w[`FCS_ST_BYPASS] = bypass_reg;
    status_w[`FCS_ST_ERASING] = erasing_reg;
    status_w[`FCS_ST_SUSPENDED] = suspended_reg;
    status_w[`FCS_ST_IDMODE] = id_mode_reg;
    status_w[`FCS_ST_ERROR] = error_reg;
    status_w[`FCS_ST_REFUSED] = refused_reg;
    status_w[`FCS_ST_PROTECTED] = protected_reg;
  end

  // Wishbone slave: ack one cycle after request
  always @(posedge core_clk) begin
    if (srst) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
      addr_reg <= `FCS_RST_ADDR;
      data_reg <= `FCS_RST_DATA;
      byte_n_reg <= ~`FCS_RST_CFG;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req & wb_we_i) begin
        if (wb_adr_i == `FCS_OFF_ADDR) begin
          addr_reg <= (addr_reg & ~wb_mask) | (wb_dat_i & wb_mask);
        end
        if (wb_adr_i == `FCS_OFF_DATA) begin
          data_reg <= (data_reg & ~wb_mask[15:0]) | (wb_dat_i[15:0] & wb_mask[15:0]);
        end
        if ((wb_adr_i == `FCS_OFF_CFG) && wb_sel_i[0] && state_reg[0]) begin
          byte_n_reg <= ~wb_dat_i[`FCS_CFG_BYTE];
        end
      end
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `FCS_OFF_CMD: wb_dat_reg <= {28'h0000000, cmd_reg};
          `FCS_OFF_ADDR: wb_dat_reg <= addr_reg;
          `FCS_OFF_DATA: wb_dat_reg <= {16'h0000, data_reg};
          `FCS_OFF_CFG: wb_dat_reg <= {31'h00000000, ~byte_n_reg};
          `FCS_OFF_STATUS: wb_dat_reg <= status_w;
          `FCS_OFF_RDATA: wb_dat_reg <= {16'h0000, rdata_reg};
          default: wb_dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command sequencer and status poller
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      cmd_reg <= `FCS_CMD_READ;
      step_reg <= 3'd0;
      bypass_reg <= 1'b0;
      erasing_reg <= 1'b0;
      sector_erase_reg <= 1'b0;
      suspended_reg <= 1'b0;
      id_mode_reg <= 1'b0;
      error_reg <= 1'b0;
      refused_reg <= 1'b0;
      protected_reg <= 1'b0;
      poll_exp_reg <= 1'b0;
      recheck_reg <= 1'b0;
      poll_addr_reg <= {AW{1'b0}};
      erase_addr_reg <= {AW{1'b0}};
      rdata_reg <= 16'h0000;
      cyc_go_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      cyc_addr_reg <= {AW{1'b0}};
      cyc_wdata_reg <= 16'h0000;
    end else begin
      cyc_go_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_req) begin
            if (cmd_ok) begin
              cmd_reg <= wb_dat_i[3:0];
              step_reg <= 3'd0;
              error_reg <= 1'b0;
              refused_reg <= 1'b0;
              recheck_reg <= 1'b0;
              if (wb_dat_i[3:0] == `FCS_CMD_POLL) begin
                poll_exp_reg <= 1'b1;
                poll_addr_reg <= erase_addr_reg;
                state_reg <= S_POLL;
              end else begin
                state_reg <= S_SEQ;
              end
            end else begin
              refused_reg <= 1'b1;
            end
          end
        end
        S_SEQ: begin
          cyc_go_reg <= 1'b1;
          cyc_wr_reg <= step_w[SW-2];
          cyc_addr_reg <= step_w[SW-3:16];
          cyc_wdata_reg <= step_w[15:0];
          state_reg <= S_SEQW;
        end
        S_SEQW: begin
          if (cyc_done) begin
            step_reg <= step_reg + 3'd1;
            if (cmd_reg == `FCS_CMD_READ) begin
              rdata_reg <= cyc_rdata;
            end
            if ((cmd_reg == `FCS_CMD_PROTECT) && (step_reg == 3'd3)) begin
              protected_reg <= cyc_rdata[0];
            end
            if (!step_last) begin
              state_reg <= S_SEQ;
            end else begin
              state_reg <= S_IDLE;
              case (cmd_reg)
                `FCS_CMD_PROG, `FCS_CMD_BYP_PROG: begin
                  // Polled from the last write's rising edge
                  poll_exp_reg <= data_reg[`FCS_POLL_BIT];
                  poll_addr_reg <= a_in;
                  state_reg <= S_POLL;
                end
                `FCS_CMD_SUSPEND: begin
                  poll_exp_reg <= 1'b1;
                  poll_addr_reg <= erase_addr_reg;
                  state_reg <= S_POLL;
                end
                `FCS_CMD_CHIP_ERASE, `FCS_CMD_SECT_ERASE: begin
                  erasing_reg <= 1'b1;
                  sector_erase_reg <= (cmd_reg == `FCS_CMD_SECT_ERASE);
                  erase_addr_reg <= a_in;
                end
                `FCS_CMD_RESUME: suspended_reg <= 1'b0;
                `FCS_CMD_BYP_ENTER: bypass_reg <= 1'b1;
                `FCS_CMD_BYP_EXIT: bypass_reg <= 1'b0;
                `FCS_CMD_CFI: id_mode_reg <= 1'b1;
                `FCS_CMD_RESET: id_mode_reg <= 1'b0;
                default: begin
                end
              endcase
            end
          end
        end
        S_POLL: begin
          cyc_go_reg <= 1'b1;
          cyc_wr_reg <= 1'b0;
          cyc_addr_reg <= poll_addr_reg;
          state_reg <= S_POLLW;
        end
        S_POLLW: begin
          if (cyc_done) begin
            if (cyc_rdata[`FCS_POLL_BIT] == poll_exp_reg) begin
              state_reg <= S_FIN;
            end else if (recheck_reg) begin
              state_reg <= S_FAIL;
            end else begin
              recheck_reg <= cyc_rdata[`FCS_TIMEOUT_BIT];
              state_reg <= S_POLL;
            end
          end
        end
        S_FIN: begin
          cyc_go_reg <= 1'b1;
          cyc_wr_reg <= 1'b0;
          cyc_addr_reg <= poll_addr_reg;
          state_reg <= S_FINW;
        end
        S_FINW: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            state_reg <= S_IDLE;
            if (cmd_reg == `FCS_CMD_SUSPEND) begin
              suspended_reg <= 1'b1;
            end
            if (cmd_reg == `FCS_CMD_POLL) begin
              erasing_reg <= 1'b0;
            end
          end
        end
        S_FAIL: begin
          cyc_go_reg <= 1'b1;
          cyc_wr_reg <= 1'b1;
          cyc_addr_reg <= {AW{1'b0}};
          cyc_wdata_reg <= {8'h00, `FCS_D_RESET};
          state_reg <= S_FAILW;
        end
        S_FAILW: begin
          if (cyc_done) begin
            error_reg <= 1'b1;
            state_reg <= S_IDLE;
            if ((cmd_reg == `FCS_CMD_POLL) || (cmd_reg == `FCS_CMD_SUSPEND)) begin
              erasing_reg <= 1'b0;
              suspended_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // fcs_top

/* File: common/fcs_regs.vh */
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// Register byte offsets
`define FCS_OFF_CMD 8'h00
`define FCS_OFF_ADDR 8'h04
`define FCS_OFF_DATA 8'h08
`define FCS_OFF_CFG 8'h0c
`define FCS_OFF_STATUS 8'h10
`define FCS_OFF_RDATA 8'h14

// Field positions
`define FCS_CFG_BYTE 0
`define FCS_ST_BUSY 0
`define FCS_ST_READY 1
`define FCS_ST_BYPASS 2
`define FCS_ST_ERASING 3
`define FCS_ST_SUSPENDED 4
`define FCS_ST_IDMODE 5
`define FCS_ST_ERROR 6
`define FCS_ST_REFUSED 7
`define FCS_ST_PROTECTED 8
`define FCS_POLL_BIT 7
`define FCS_TIMEOUT_BIT 5

// Reset values
`define FCS_RST_ADDR 32'h0000_0000
`define FCS_RST_DATA 16'h0000
`define FCS_RST_CFG 1'b0

// Controller commands
`define FCS_CMD_READ 4'h0
`define FCS_CMD_PROG 4'h1
`define FCS_CMD_BYP_ENTER 4'h2
`define FCS_CMD_BYP_PROG 4'h3
`define FCS_CMD_BYP_EXIT 4'h4
`define FCS_CMD_CHIP_ERASE 4'h5
`define FCS_CMD_SECT_ERASE 4'h6
`define FCS_CMD_SUSPEND 4'h7
`define FCS_CMD_RESUME 4'h8
`define FCS_CMD_CFI 4'h9
`define FCS_CMD_RESET 4'ha
`define FCS_CMD_PROTECT 4'hb
`define FCS_CMD_POLL 4'hc

// Flash command data
`define FCS_D_UNLOCK1 8'haa
`define FCS_D_UNLOCK2 8'h55
`define FCS_D_PROG 8'ha0
`define FCS_D_BYPASS 8'h20
`define FCS_D_BYP_EXIT1 8'h90
`define FCS_D_BYP_EXIT2 8'h00
`define FCS_D_ERASE 8'h80
`define FCS_D_CHIP 8'h10
`define FCS_D_SECTOR 8'h30
`define FCS_D_SUSPEND 8'hb0
`define FCS_D_RESUME 8'h30
`define FCS_D_CFI 8'h98
`define FCS_D_AUTOSEL 8'h90
`define FCS_D_RESET 8'hf0

// Flash unlock, CFI query and protect-verify addresses
`define FCS_A_WORD1 12'h555
`define FCS_A_WORD2 12'h2aa
`define FCS_A_BYTE1 12'haaa
`define FCS_A_BYTE2 12'h555
`define FCS_A_CFI_WORD 12'h055
`define FCS_A_CFI_BYTE 12'h0aa
`define FCS_A_PV_WORD 12'h002
`define FCS_A_PV_BYTE 12'h004

// Timing
`define FCS_CLK_NS 10
`define FCS_T_SETUP_NS 20
`define FCS_T_PULSE_NS 100
`define FCS_T_HOLD_NS 20
`define FCS_SETUP_CYC ((`FCS_T_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_PULSE_CYC ((`FCS_T_PULSE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_HOLD_CYC ((`FCS_T_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

/* File: hw/fcs_sync.v */
module fcs_sync #(
  parameter W = 17
) (
  input wire core_clk,
  input wire srst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge core_clk) begin
        if (srst) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule // fcs_sync

/* File: hw/fcs_cycle.v */
`include "fcs_regs.vh"

module fcs_cycle #(
  parameter AW = 20,
  parameter SETUP = `FCS_SETUP_CYC,
  parameter PULSE = `FCS_PULSE_CYC,
  parameter HOLD = `FCS_HOLD_CYC
) (
  input wire core_clk,
  input wire srst,
  input wire go,
  input wire wr,
  input wire [AW-1:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_sync,
  output reg done,
  output reg [15:0] rdata,
  output reg [AW-1:0] fl_addr,
  output reg [15:0] fl_dq_out,
  output reg fl_dq_oe_n,
  output reg fl_ce_n,
  output reg fl_we_n,
  output reg fl_oe_n
);
  localparam [4:0] C_IDLE = 5'b00001;
  localparam [4:0] C_SETUP = 5'b00010;
  localparam [4:0] C_PULSE = 5'b00100;
  localparam [4:0] C_HOLD = 5'b01000;
  localparam [4:0] C_GAP = 5'b10000;
  localparam [31:0] LS = SETUP - 1;
  localparam [31:0] LP = PULSE - 1;
  localparam [31:0] LH = HOLD - 1;

  reg [4:0] state_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;

  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= {AW{1'b0}};
      fl_dq_out <= 16'h0000;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (go) begin
            wr_reg <= wr;
            fl_addr <= addr;
            fl_dq_out <= wdata;
            fl_dq_oe_n <= ~wr;
            fl_oe_n <= wr;
            fl_ce_n <= 1'b0;
            cnt_reg <= 8'h00;
            state_reg <= C_SETUP;
          end
        end
        C_SETUP: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == LS[7:0]) begin
            // Address latched by device on this falling edge
            fl_we_n <= ~wr_reg;
            cnt_reg <= 8'h00;
            state_reg <= C_PULSE;
          end
        end
        C_PULSE: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == LP[7:0]) begin
            if (!wr_reg) begin
              rdata <= dq_sync;
            end
            // Data latched by device on this rising edge, still driven
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            cnt_reg <= 8'h00;
            state_reg <= C_HOLD;
          end
        end
        C_HOLD: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == LH[7:0]) begin
            fl_ce_n <= 1'b1;
            fl_dq_oe_n <= 1'b1;
            done <= 1'b1;
            state_reg <= C_GAP;
          end
        end
        C_GAP: begin
          state_reg <= C_IDLE;
        end
        default: begin
          state_reg <= C_IDLE;
        end
      endcase
    end
  end
endmodule // fcs_cycle

/* File: testbench/fcs_assertions.sv */
module fcs_chk #(
  parameter AW = 20
) (
  input wire core_clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [AW-1:0] fl_addr,
  input wire [15:0] fl_dq_out,
  input wire fl_dq_oe_n,
  input wire fl_ce_n,
  input wire fl_we_n,
  input wire fl_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence wr_pulse;
    !fl_we_n [*8];
  endsequence
  sequence wr_tail;
    (fl_we_n && !fl_ce_n) [*2];
  endsequence
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_WE_QUAL: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && !fl_dq_oe_n)
    else $error("write strobe without chip select or data");
  AST_SETUP: assert property ($fell(fl_we_n) |-> $past(fl_ce_n, 2) == 1'b0)
    else $error("write strobe without setup");
  AST_PULSE: assert property ($fell(fl_we_n) |-> wr_pulse)
    else $error("write pulse too short");
  AST_HOLD: assert property ($rose(fl_we_n) |-> wr_tail)
    else $error("chip select released with write strobe");
  AST_STABLE: assert property (!fl_we_n ##1 !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved during write");
  AST_READ: assert property (!fl_oe_n |-> fl_dq_oe_n && !fl_ce_n && fl_we_n)
    else $error("read while driving data");
endmodule // fcs_chk

/* File: testbench/fcs_flash_model.sv */
module fcs_flash_model (
  input wire core_clk,
  input wire [19:0] fl_addr,
  input wire [15:0] fl_dq_out,
  output wire [15:0] fl_dq_in,
  input wire fl_ce_n,
  input wire fl_we_n,
  input wire fl_oe_n,
  input wire fl_byte_n,
  output wire ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [19:0] la = 20'h0;
  reg [19:0] pa = 20'hfffff;
  reg [15:0] pd = 16'hffff;
  reg [15:0] pw = 16'hffff;
  reg [2:0] u = 3'h0;
  reg arm = 0, byp = 0, bx = 0, sus = 0, pb = 0, eb = 0, se = 0, qm = 0, idm = 0;
  time pend = 0, eend = 0, ts = 0;
  // Arbitrary protected sector and query reply
  localparam [7:0] PS = 8'h7f;
  localparam [15:0] QRY = 16'h00c3;
  wire [7:0] d = fl_dq_out[7:0];
  wire [11:0] a1 = fl_byte_n ? 12'h555 : 12'haaa;
  wire [11:0] a2 = fl_byte_n ? 12'h2aa : 12'h555;
  wire [11:0] aq = fl_byte_n ? 12'h055 : 12'h0aa;
  wire [15:0] st = {pw[15:8], ~pw[7], pw[6], 1'b0, pw[4:0]};
  wire [15:0] rd = qm ? QRY : idm ? {15'h0, fl_addr[19:12] == PS} :
    pb ? st : (eb && !sus) ? 16'h0 :
    (fl_addr == pa) ? pd : eb ? 16'h0080 : 16'hffff;
  // Released bus shows the inverse so a stale value never passes
  assign fl_dq_in = fl_oe_n ? ~rd : rd;
  assign ready_busy_n = !(pb || (eb && !sus));
  always @(posedge core_clk) begin
    pb <= $time < pend;
    eb <= sus || $time < eend;
  end
  always @(negedge fl_we_n) if (!fl_ce_n) la <= fl_addr;
  always @(posedge fl_we_n) begin
    if (arm) begin
      pw <= fl_dq_out;
      if (la[19:12] == PS) begin
        pend <= $time + 1000;
      end else begin
        pa <= la;
        pd <= fl_dq_out;
        pend <= $time + 2000;
      end
      arm <= 0;
    end else if (eb && !sus) begin
      if (d == 8'hb0 && se) begin
        sus <= 1;
        ts <= $time;
      end
    end else if (sus && d == 8'h30) begin
      sus <= 0;
      eend <= eend + $time - ts;
    end else if (byp) begin
      arm <= d == 8'ha0;
      bx <= d == 8'h90;
      if (bx && d == 8'h00) byp <= 0;
    end else if (d == 8'hf0) begin
      qm <= 0;
      idm <= 0;
      u <= 3'h0;
    end else if (d == 8'h98 && u == 3'h0 && la[11:0] == aq &&
        !pb && (!eb || idm)) begin
      qm <= 1;
    end else begin
      case (u)
        0, 3: u <= (d == 8'haa && la[11:0] == a1) ? u + 3'h1 : 3'h0;
        1, 4: u <= (d == 8'h55 && la[11:0] == a2) ? u + 3'h1 : 3'h0;
        2: begin
          arm <= d == 8'ha0;
          byp <= d == 8'h20;
          if (d == 8'h90) idm <= 1;
          u <= (d == 8'h80) ? 3'h3 : 3'h0;
        end
        default: begin
          if (d == 8'h10 || d == 8'h30) begin
            eend <= $time + ((d == 8'h30 && la[19:12] == PS) ? 100000 : 30000);
          end
          se <= d == 8'h30;
          u <= 3'h0;
        end
      endcase
    end
  end
endmodule // fcs_flash_model

/* File: testbench/fcs_top_tb.sv */
module fcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, r;
  wire [31:0] wb_dat_o;
  wire [19:0] fl_addr;
  wire [15:0] fl_dq_out, fl_dq_in;
  wire wb_ack_o, fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_byte_n, ready_busy_n;
  integer err_count = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  fcs_top #(.AW(20)) uut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_byte_n(fl_byte_n), .ready_busy_n(ready_busy_n));
  fcs_flash_model flash (.core_clk(core_clk), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_byte_n(fl_byte_n), .ready_busy_n(ready_busy_n));
  task complete_run;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw,
    output logic [31:0] dr);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dw;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    dr = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Issue a command and wait for the sequencer to go idle
  task automatic run(input logic [3:0] c);
    logic [31:0] s;
    wb(1, 8'h00, {28'h0, c}, s);
    s = 32'h1;
    while (s[0] !== 1'b0) wb(0, 8'h10, 32'h0, s);
  endtask
  initial begin
    #500us;
    err_count++;
    $display("unexpected %0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 0;
    @(posedge core_clk);
    rdc(8'h0c, 32'h1, 32'h0);
    rdc(8'h3c, 32'hffffffff, 32'h0);
    wb(1, 8'h04, 32'h00012340, r);
    wb(1, 8'h08, 32'h0000a55a, r);
    run(4'h1);
    rdc(8'h14, 32'hffff, 32'ha55a);
    rdc(8'h10, 32'h40, 32'h0);
    wb(1, 8'h0c, 32'h1, r);
    wb(1, 8'h08, 32'h0000003c, r);
    run(4'h1);
    rdc(8'h14, 32'hffff, 32'h003c);
    wb(1, 8'h0c, 32'h0, r);
    run(4'h2);
    rdc(8'h10, 32'h4, 32'h4);
    wb(1, 8'h08, 32'h00007e81, r);
    run(4'h3);
    rdc(8'h14, 32'hffff, 32'h7e81);
    run(4'h4);
    rdc(8'h10, 32'h4, 32'h0);
    run(4'h9);
    rdc(8'h10, 32'h20, 32'h20);
    run(4'h0);
    rdc(8'h14, 32'hffff, 32'h00c3);
    run(4'ha);
    rdc(8'h10, 32'h20, 32'h0);
    run(4'h0);
    rdc(8'h14, 32'hffff, 32'h7e81);
    run(4'hb);
    rdc(8'h10, 32'h100, 32'h0);
    wb(1, 8'h04, 32'h0007f000, r);
    run(4'hb);
    rdc(8'h10, 32'h100, 32'h100);
    wb(1, 8'h08, 32'h00000080, r);
    run(4'h1);
    rdc(8'h14, 32'hffff, 32'hffff);
    run(4'h6);
    rdc(8'h10, 32'h0a, 32'h08);
    run(4'hc);
    rdc(8'h10, 32'h5a, 32'h02);
    run(4'h7);
    rdc(8'h10, 32'h80, 32'h80);
    wb(1, 8'h04, 32'h00080000, r);
    run(4'h6);
    rdc(8'h10, 32'h0a, 32'h08);
    run(4'h7);
    rdc(8'h10, 32'h1a, 32'h1a);
    run(4'h8);
    rdc(8'h10, 32'h12, 32'h0);
    run(4'hc);
    rdc(8'h10, 32'h5a, 32'h02);
    run(4'h5);
    run(4'h7);
    rdc(8'h10, 32'h88, 32'h88);
    run(4'hc);
    rdc(8'h10, 32'h5a, 32'h02);
    complete_run;
  end
endmodule // fcs_top_tb
bind fcs_top fcs_chk #(.AW(AW)) u_chk (.core_clk(core_clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n));
